// [fpc_console.sv]
/*
 fpc_console: front panel control logic between operator switches and the cpu.
 assumes: switches already debounced and synchronous to i_clk_sys; cpu answers
 reads with i_cpu_rvalid; cpu reports instruction boundaries and idle halts.
*/
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - while halted, show memory or eleven registers; enter memory or ten registers
// - run or single mode: indicators show the current instruction address
// - memory power fail lamp latches on power return until system reset
// - idle halt lights idle lamp, darkens run; cleared by start in run/single
// - run lamp lit by start in run mode, dark once run mode is left
// - breakpoint centred: lamp lights on address match in run/single; no halt
// - breakpoint clear extinguishes the lamp in any mode
// - breakpoint up in run: match lights lamp, halt after that instruction
// - panel lock ignores all but data, sense, breakpoint clear; no breakpoint halt; clock switch and leaving run mode still act
// - sixteen data switches: up is one; entry value and breakpoint address
// - instruction register display acts only while halted
// - enter loads data switches into target and shows it; display shows target
// - memory entry or display uses the memory address register as address
// - register and memory switches act only while halted
// - increment switch acts as memory data then bumps memory address register
// - four sense switches offered to both sense test instructions
// - system reset clears program counter, flags, memory address and display
// - halt selector stops after current instruction; start enters selected mode
// - single mode start runs one instruction; run mode start runs continuously
// - clock switch on runs freely; off stops clock; step gives one pulse
// - load while halted copies 256 firmware words to memory from zero
// - after load, run selector starts at program counter, halt waits for start
module fpc_console #(
    parameter int BOOT_N = 256
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // operator switches
    input wire logic [1:0] i_mode_sel,
    input wire logic i_clk_on,
    input wire logic [1:0] i_breakpoint_sw,
    input wire logic i_start_sw,
    input wire logic i_reset_sw,
    input wire logic i_load_sw,
    input wire logic i_step_sw,
    input wire logic i_ir_sw,
    input wire logic [3:0] i_tgt_sel,
    input wire logic i_enter_sw,
    input wire logic i_disp_sw,
    input wire logic i_incr_sw,
    // cpu status
    input wire logic i_instr_done,
    input wire logic i_idle_halt,
    input wire logic [15:0] i_cur_addr,
    input wire logic [15:0] i_mar,
    input wire logic i_cpu_rvalid,
    input wire logic [15:0] i_cpu_rdata,
    input wire logic i_mem_pwr_lost,
    input wire logic i_ac_ok,
    input wire logic [15:0] i_boot_word,
    // cpu control
    output fpc_pkg::fpc_cpu_req_t o_cpu,
    output logic [7:0] o_boot_idx,
    output logic [3:0] o_sense,
    // lamps
    output logic [15:0] o_data_lamps,
    output logic o_run_lamp,
    output logic o_idle_lamp,
    output logic o_breakpoint_lamp,
    output logic o_pwr_fail_lamp
);
    typedef struct packed {
        fpc_pkg::fpc_state_t st;
        logic [9:0] prev;
        logic [15:0] disp;
        logic [21:0] swreg;
        logic [8:0] boot_cnt;
        logic run_l;
        logic idle_l;
        logic breakpoint_l;
        logic pf_l;
        logic rd_wait;
        logic rd_incr;
        logic step_pend;
        logic breakpoint_halt;
        fpc_pkg::fpc_cpu_req_t cpu;
        logic [31:0] wb_dat;
        logic wb_ack;
    } fpc_state_reg_t;

    fpc_state_reg_t s_q, s_d;
    fpc_pkg::fpc_btn_t btn;
    logic [9:0] raw;
    logic [15:0] data_sw;
    logic locked;
    logic halted;
    logic match;
    logic wb_hit;

    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction

    assign raw = {i_start_sw, i_reset_sw, i_load_sw, i_step_sw, i_breakpoint_sw[0],
                  i_ir_sw, i_enter_sw, i_disp_sw, i_incr_sw, 1'b0};
    assign data_sw = s_q.swreg[fpc_pkg::SW_DATA_LSB +: 16];
    assign locked = s_q.swreg[fpc_pkg::SW_LOCK];
    assign halted = (s_q.st == fpc_pkg::ST_HALT);
    assign match = (i_mar == data_sw);
    assign wb_hit = i_wb_cyc & i_wb_stb & ~s_q.wb_ack;

    always_comb begin
        s_d = s_q;
        // one pulse per actuation; lock masks all but breakpoint clear
        btn.start = rise(raw[9], s_q.prev[9]) & ~locked;
        btn.reset = rise(raw[8], s_q.prev[8]) & ~locked;
        btn.load = rise(raw[7], s_q.prev[7]) & ~locked;
        btn.step = rise(raw[6], s_q.prev[6]) & ~locked;
        btn.breakpoint_clr = rise(raw[5], s_q.prev[5]);
        btn.ir_disp = rise(raw[4], s_q.prev[4]) & ~locked;
        btn.enter = rise(raw[3], s_q.prev[3]) & ~locked;
        btn.disp = rise(raw[2], s_q.prev[2]) & ~locked;
        btn.incr = rise(raw[1], s_q.prev[1]) & ~locked;
        s_d.prev = raw;
        s_d.cpu.reg_wr = 1'b0;
        s_d.cpu.reg_rd = 1'b0;
        s_d.cpu.mem_wr = 1'b0;
        s_d.cpu.mem_rd = 1'b0;
        s_d.cpu.sys_reset = 1'b0;
        s_d.wb_ack = 1'b0;
        // clock gating: jumper removes switch control
        s_d.cpu.clk_en = i_clk_on | ~s_q.swreg[fpc_pkg::SW_CLKEN_JMP] | btn.step;

        // execution sequencing
        unique case (s_q.st)
            fpc_pkg::ST_HALT: begin
                if (btn.start && i_mode_sel == fpc_pkg::MODE_RUN) begin
                    s_d.st = fpc_pkg::ST_RUN;
                    s_d.run_l = 1'b1;
                    s_d.idle_l = 1'b0;
                end else if (btn.start && i_mode_sel == fpc_pkg::MODE_SINGLE) begin
                    s_d.st = fpc_pkg::ST_STEP;
                    s_d.idle_l = 1'b0;
                end else if (btn.load) begin
                    s_d.st = fpc_pkg::ST_BOOT;
                    s_d.boot_cnt = 9'h000;
                end
            end
            fpc_pkg::ST_RUN: begin
                if (i_idle_halt) begin
                    s_d.st = fpc_pkg::ST_HALT;
                    s_d.idle_l = 1'b1;
                    s_d.run_l = 1'b0;
                end else if (i_mode_sel != fpc_pkg::MODE_RUN || s_q.breakpoint_halt) begin
                    s_d.st = fpc_pkg::ST_STOP;
                    s_d.run_l = 1'b0;
                end
            end
            fpc_pkg::ST_STEP, fpc_pkg::ST_STOP: begin
                // wait for the instruction in flight to finish
                if (i_idle_halt) begin
                    s_d.st = fpc_pkg::ST_HALT;
                    s_d.idle_l = 1'b1;
                end else if (i_instr_done) begin
                    s_d.st = fpc_pkg::ST_HALT;
                end
            end
            fpc_pkg::ST_BOOT: begin
                s_d.cpu.mem_wr = 1'b1;
                s_d.cpu.maddr = {7'h00, s_q.boot_cnt};
                s_d.cpu.wdata = i_boot_word;
                s_d.boot_cnt = s_q.boot_cnt + 9'h001;
                if (s_q.boot_cnt == 9'(BOOT_N - 1)) begin
                    // run selector starts straight away, else stay halted
                    if (i_mode_sel == fpc_pkg::MODE_RUN) begin
                        s_d.st = fpc_pkg::ST_RUN;
                        s_d.run_l = 1'b1;
                    end else begin
                        s_d.st = fpc_pkg::ST_HALT;
                    end
                end
            end
            default: s_d.st = fpc_pkg::ST_HALT;
        endcase
        // stop keeps run up, else the instruction in flight never finishes
        s_d.cpu.run = (s_d.st == fpc_pkg::ST_RUN) || (s_d.st == fpc_pkg::ST_STOP);
        s_d.cpu.single = (s_d.st == fpc_pkg::ST_STEP);
        s_d.breakpoint_halt = 1'b0;

        // breakpoint lamp; armed halt only when unlocked and switch up
        if (!halted && s_q.st != fpc_pkg::ST_BOOT && match) begin
            s_d.breakpoint_l = 1'b1;
            if (s_q.st == fpc_pkg::ST_RUN && i_breakpoint_sw[1] && !locked) begin
                s_d.breakpoint_halt = 1'b1;
            end
        end
        if (btn.breakpoint_clr && !match) begin
            s_d.breakpoint_l = 1'b0;
        end else if (btn.breakpoint_clr) begin
            s_d.breakpoint_l = 1'b0;
        end

        // manual display and entry, halted only
        if (halted && !s_q.rd_wait) begin
            if (btn.ir_disp) begin
                s_d.cpu.reg_rd = 1'b1;
                s_d.cpu.sel = fpc_pkg::TGT_IR;
                s_d.rd_wait = 1'b1;
                s_d.rd_incr = 1'b0;
            end else if (btn.enter || btn.disp) begin
                s_d.cpu.sel = i_tgt_sel;
                s_d.cpu.maddr = i_mar;
                s_d.rd_incr = btn.incr;
                if (btn.enter) begin
                    s_d.cpu.wdata = data_sw;
                    s_d.disp = data_sw;
                    s_d.cpu.mem_wr = (i_tgt_sel == fpc_pkg::TGT_MEM);
                    s_d.cpu.reg_wr = (i_tgt_sel < fpc_pkg::TGT_MEM);
                end else if (i_tgt_sel < 4'(fpc_pkg::NUM_TGT)) begin
                    s_d.cpu.mem_rd = (i_tgt_sel == fpc_pkg::TGT_MEM);
                    s_d.cpu.reg_rd = (i_tgt_sel != fpc_pkg::TGT_MEM);
                    s_d.rd_wait = 1'b1;
                end
            end
        end
        // memory increment after enter, or after a completed read
        if (s_q.rd_incr && !s_q.rd_wait && !s_q.cpu.reg_wr) begin
            s_d.cpu.reg_wr = 1'b1;
            s_d.cpu.sel = fpc_pkg::TGT_MAR;
            s_d.cpu.wdata = i_mar + 16'h0001;
            s_d.rd_incr = 1'b0;
        end
        if (s_q.rd_wait && i_cpu_rvalid) begin
            s_d.disp = i_cpu_rdata;
            s_d.rd_wait = 1'b0;
        end

        // power fail lamp latches; a new set in the same cycle wins over reset
        if (i_mem_pwr_lost && i_ac_ok) begin
            s_d.pf_l = 1'b1;
        end

        // system reset switch
        if (btn.reset) begin
            s_d.cpu.sys_reset = 1'b1;
            s_d.disp = fpc_pkg::RST_WORD;
            s_d.pf_l = i_mem_pwr_lost & i_ac_ok;
        end

        // wishbone register access
        if (wb_hit) begin
            s_d.wb_ack = 1'b1;
            s_d.wb_dat = 32'h0000_0000;
            unique case (i_wb_adr)
                fpc_pkg::OFS_SWITCH: begin
                    s_d.wb_dat = {10'h000, s_q.swreg};
                    if (i_wb_we) begin
                        if (i_wb_sel[0]) s_d.swreg[7:0] = i_wb_dat[7:0];
                        if (i_wb_sel[1]) s_d.swreg[15:8] = i_wb_dat[15:8];
                        if (i_wb_sel[2]) s_d.swreg[21:16] = i_wb_dat[21:16];
                    end
                end
                fpc_pkg::OFS_LAMPS: s_d.wb_dat = {28'h0000000, s_q.pf_l, s_q.breakpoint_l, s_q.idle_l, s_q.run_l};
                fpc_pkg::OFS_DISPLAY: s_d.wb_dat = {16'h0000, o_data_lamps};
                fpc_pkg::OFS_STATUS: s_d.wb_dat = {27'h0000000, s_q.rd_wait, s_q.breakpoint_halt, s_q.st};
                default: s_d.wb_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
            s_q.swreg <= 22'h200000;
        end else begin
            s_q <= s_d;
        end
    end

    // running: show the executing address, halted: display register
    assign o_data_lamps = (s_q.st == fpc_pkg::ST_RUN || s_q.st == fpc_pkg::ST_STEP) ? i_cur_addr : s_q.disp;
    assign o_sense = s_q.swreg[fpc_pkg::SW_SENSE_LSB +: 4];
    assign o_cpu = s_q.cpu;
    assign o_boot_idx = s_q.boot_cnt[7:0];
    assign o_run_lamp = s_q.run_l;
    assign o_idle_lamp = s_q.idle_l;
    assign o_breakpoint_lamp = s_q.breakpoint_l;
    assign o_pwr_fail_lamp = s_q.pf_l;
    assign o_wb_dat = s_q.wb_dat;
    assign o_wb_ack = s_q.wb_ack;
endmodule // fpc_console

// [fpc_pkg.sv]
/*
 fpc_pkg: constants, types and register map of the operator console block.
 assumes: single 10 MHz system clock, classic wishbone register access.
*/
package fpc_pkg;
    localparam int DW = 16;
    // wishbone byte addresses
    localparam logic [7:0] OFS_SWITCH = 8'h00;
    localparam logic [7:0] OFS_LAMPS = 8'h04;
    localparam logic [7:0] OFS_DISPLAY = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    // switch register fields
    localparam int SW_DATA_LSB = 0;
    localparam int SW_SENSE_LSB = 16;
    localparam int SW_LOCK = 20;
    localparam int SW_CLKEN_JMP = 21;
    // display targets: 0..8 registers, 9 memory address, 10 memory data, 11 instruction register
    localparam logic [3:0] TGT_PC = 4'h0;
    localparam logic [3:0] TGT_FLAGS = 4'h8;
    localparam logic [3:0] TGT_MAR = 4'h9;
    localparam logic [3:0] TGT_MEM = 4'ha;
    localparam logic [3:0] TGT_IR = 4'hb;
    localparam int NUM_TGT = 12;
    localparam logic [8:0] BOOT_WORDS = 9'h100;
    localparam logic [DW-1:0] RST_WORD = 16'h0000;

    typedef enum logic [1:0] {
        MODE_HALT = 2'b00,
        MODE_RUN = 2'b01,
        MODE_SINGLE = 2'b11
    } fpc_mode_t;

    typedef enum logic [2:0] {
        ST_HALT = 3'b000,
        ST_RUN = 3'b001,
        ST_STEP = 3'b011,
        ST_BOOT = 3'b010,
        ST_STOP = 3'b110
    } fpc_state_t;

    // momentary switch pulses after synchronisation
    typedef struct packed {
        logic start;
        logic reset;
        logic load;
        logic step;
        logic breakpoint_clr;
        logic ir_disp;
        logic enter;
        logic disp;
        logic incr;
    } fpc_btn_t;

    // cpu-side request group
    typedef struct packed {
        logic run;
        logic single;
        logic clk_en;
        logic sys_reset;
        logic reg_wr;
        logic reg_rd;
        logic mem_wr;
        logic mem_rd;
        logic [3:0] sel;
        logic [DW-1:0] wdata;
        logic [DW-1:0] maddr;
    } fpc_cpu_req_t;
endpackage

// [fpc_checker.sv]
/*
 fpc_checker: concurrent checks on the console ports, bound into fpc_console.
 assumes: one clock domain, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module fpc_checker (
    // clock, reset and bus
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // switches and cpu side
    input wire logic [1:0] i_breakpoint_sw,
    input wire logic i_idle_halt,
    input wire logic [15:0] i_cur_addr,
    input wire logic i_mem_pwr_lost,
    input wire logic i_ac_ok,
    input wire fpc_pkg::fpc_cpu_req_t o_cpu,
    // lamps
    input wire logic [15:0] o_data_lamps,
    input wire logic o_run_lamp,
    input wire logic o_idle_lamp,
    input wire logic o_breakpoint_lamp,
    input wire logic o_pwr_fail_lamp
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    a_ack_timely: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus request not answered next cycle");
    a_lamp_read: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && !i_wb_we && i_wb_adr == fpc_pkg::OFS_LAMPS
        |=> o_wb_dat[3:0] == $past({o_pwr_fail_lamp, o_breakpoint_lamp, o_idle_lamp, o_run_lamp}))
        else $error("lamp register read differs from lamps");
    a_pwr_lamp_on: assert property (i_mem_pwr_lost && i_ac_ok |-> ##[1:2] o_pwr_fail_lamp)
        else $error("power fail lamp not lit");
    a_idle_lamps: assert property (i_idle_halt |-> ##[1:2] (o_idle_lamp && !o_run_lamp))
        else $error("idle halt did not swap lamps");
    a_breakpoint_clear: assert property ($rose(i_breakpoint_sw[0]) |-> ##[1:2] !o_breakpoint_lamp)
        else $error("breakpoint clear left lamp lit");
    a_run_display: assert property (o_run_lamp && $past(o_run_lamp) && $stable(i_cur_addr)
        |-> o_data_lamps == i_cur_addr)
        else $error("running display not the instruction address");
    a_boot_seq: assert property (o_cpu.mem_wr && $past(o_cpu.mem_wr)
        |-> o_cpu.maddr == $past(o_cpu.maddr) + 16'h0001)
        else $error("firmware load address not consecutive");
    a_reset_pulse: assert property (o_cpu.sys_reset |=> !o_cpu.sys_reset)
        else $error("system reset longer than one pulse");
endmodule // fpc_checker

bind fpc_console fpc_checker u_fpc_checker (.i_clk_sys, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .o_wb_dat, .o_wb_ack, .i_breakpoint_sw, .i_idle_halt, .i_cur_addr, .i_mem_pwr_lost, .i_ac_ok, .o_cpu,
    .o_data_lamps, .o_run_lamp, .o_idle_lamp, .o_breakpoint_lamp, .o_pwr_fail_lamp);

// [fpc_cpu_model.sv]
/*
 fpc_cpu_model: behavioural cpu with register file and memory facing the console.
 assumes: requests arrive as registered pulses; one instruction every four enabled cycles.
*/
`timescale 1ns/1ps
module fpc_cpu_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // from the console and bench
    input wire fpc_pkg::fpc_cpu_req_t i_req,
    input wire logic [7:0] i_boot_idx,
    input wire logic i_idle_cmd,
    // back to the console
    output logic o_instr_done,
    output logic o_idle_halt,
    output logic o_rvalid,
    output logic [15:0] o_rdata,
    output logic [15:0] o_cur_addr,
    output logic [15:0] o_mar,
    output logic [15:0] o_boot_word
);
    logic [15:0] regs [0:11];
    logic [15:0] mem [0:255];
    logic [15:0] rd_q;
    logic [1:0] cnt;
    assign o_cur_addr = regs[0];
    assign o_mar = regs[9];
    assign o_boot_word = {8'hb0, i_boot_idx};
    // stale data inverted so a late sample never matches by luck
    assign o_rdata = o_rvalid ? rd_q : ~rd_q;
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < 12; i++) regs[i] <= 16'h0000;
            regs[8] <= 16'h00f0;
            regs[11] <= 16'h7e01;
            cnt <= 2'h0;
            o_rvalid <= 1'b0;
            o_instr_done <= 1'b0;
            o_idle_halt <= 1'b0;
        end else begin
            o_rvalid <= i_req.reg_rd | i_req.mem_rd;
            rd_q <= i_req.mem_rd ? mem[i_req.maddr[7:0]] : regs[i_req.sel];
            o_instr_done <= 1'b0;
            o_idle_halt <= 1'b0;
            if (i_req.reg_wr) regs[i_req.sel] <= i_req.wdata;
            if (i_req.mem_wr) mem[i_req.maddr[7:0]] <= i_req.wdata;
            if (i_req.sys_reset) begin
                regs[0] <= 16'h0000;
                regs[8] <= 16'h0000;
                regs[9] <= 16'h0000;
            end
            if ((i_req.run | i_req.single) && i_req.clk_en) begin
                cnt <= cnt + 2'h1;
                if (cnt == 2'h3) begin
                    o_instr_done <= 1'b1;
                    o_idle_halt <= i_idle_cmd;
                    regs[0] <= regs[0] + 16'h0001;
                    regs[9] <= regs[0] + 16'h0001;
                end
            end
        end
    end
endmodule // fpc_cpu_model

// [tb.sv]
/*
 tb: scenario bench for fpc_console with the cpu model on its far side.
 assumes: fpc_pkg compiled first; checker bound from its own file.
*/
`timescale 1ns/1ps
module tb;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, o_wb_ack;
    logic [7:0] i_wb_adr = 8'h00;
    logic [3:0] i_wb_sel = 4'hf, i_tgt_sel = 4'h0, o_sense;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rdat;
    logic [1:0] i_mode_sel = 2'b00, i_breakpoint_sw = 2'b00;
    logic i_clk_on = 1'b1, i_mem_pwr_lost = 1'b0, i_ac_ok = 1'b1, idle_cmd = 1'b0;
    logic i_start_sw = 1'b0, i_reset_sw = 1'b0, i_load_sw = 1'b0, i_step_sw = 1'b0;
    logic i_ir_sw = 1'b0, i_enter_sw = 1'b0, i_disp_sw = 1'b0, i_incr_sw = 1'b0;
    logic i_instr_done, i_idle_halt, i_cpu_rvalid, o_run_lamp, o_idle_lamp, o_breakpoint_lamp, o_pwr_fail_lamp;
    logic [15:0] i_cur_addr, i_mar, i_cpu_rdata, i_boot_word, o_data_lamps;
    logic [7:0] o_boot_idx;
    fpc_pkg::fpc_cpu_req_t o_cpu;
    int n_errors = 0, total_checks = 0, n_done = 0, n_clk = 0;
    always #50 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        n_done <= n_done + int'(i_instr_done === 1'b1);
        n_clk <= n_clk + int'(o_cpu.clk_en === 1'b1);
    end
    fpc_console u_fpc_console (.i_clk_sys, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
        .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_mode_sel, .i_clk_on, .i_breakpoint_sw, .i_start_sw, .i_reset_sw,
        .i_load_sw, .i_step_sw, .i_ir_sw, .i_tgt_sel, .i_enter_sw, .i_disp_sw, .i_incr_sw, .i_instr_done,
        .i_idle_halt, .i_cur_addr, .i_mar, .i_cpu_rvalid, .i_cpu_rdata, .i_mem_pwr_lost, .i_ac_ok,
        .i_boot_word, .o_cpu, .o_boot_idx, .o_sense, .o_data_lamps, .o_run_lamp, .o_idle_lamp,
        .o_breakpoint_lamp, .o_pwr_fail_lamp);
    fpc_cpu_model u_fpc_cpu_model (.i_clk_sys, .i_arst_n, .i_req(o_cpu), .i_boot_idx(o_boot_idx),
        .i_idle_cmd(idle_cmd), .o_instr_done(i_instr_done), .o_idle_halt(i_idle_halt),
        .o_rvalid(i_cpu_rvalid), .o_rdata(i_cpu_rdata), .o_cur_addr(i_cur_addr), .o_mar(i_mar),
        .o_boot_word(i_boot_word));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_clk_sys);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
        do begin
            @(posedge i_clk_sys);
            k++;
        end while (o_wb_ack !== 1'b1 && k < 50);
        n_errors += int'(k >= 50);
        rdat = o_wb_dat;
        {i_wb_cyc, i_wb_stb} <= 2'b00;
        @(posedge i_clk_sys);
    endtask
    task automatic sw(input logic [15:0] d, input logic lk);
        wb(1'b1, fpc_pkg::OFS_SWITCH, {10'h000, 1'b1, lk, 4'h5, d});
    endtask
    task automatic press(input logic [7:0] m);
        @(posedge i_clk_sys);
        {i_incr_sw, i_disp_sw, i_enter_sw, i_ir_sw, i_step_sw, i_load_sw, i_reset_sw, i_start_sw} <= m;
        repeat (3) @(posedge i_clk_sys);
        {i_incr_sw, i_disp_sw, i_enter_sw, i_ir_sw, i_step_sw, i_load_sw, i_reset_sw, i_start_sw} <= 8'h00;
        repeat (6) @(posedge i_clk_sys);
    endtask
    task automatic t_enter;
        sw(16'h1234, 1'b0);
        wb(1'b0, fpc_pkg::OFS_SWITCH, 32'h0);
        chk(rdat[20:0], 21'h051234);
        chk(o_sense, 4'h5);
        wb(1'b0, 8'h40, 32'h0);
        chk(rdat, 32'h0);
        wb(1'b0, fpc_pkg::OFS_LAMPS, 32'h0);
        chk(rdat[3:0], 4'h0);
        i_tgt_sel <= 4'h3;
        press(8'h20);
        chk(u_fpc_cpu_model.regs[3], 16'h1234);
        chk(o_data_lamps, 16'h1234);
        sw(16'h0010, 1'b0);
        i_tgt_sel <= fpc_pkg::TGT_MAR;
        press(8'h20);
        sw(16'hbeef, 1'b0);
        i_tgt_sel <= fpc_pkg::TGT_MEM;
        press(8'ha0);
        chk(u_fpc_cpu_model.mem[16], 16'hbeef);
        chk(u_fpc_cpu_model.regs[9], 16'h0011);
        i_tgt_sel <= 4'h3;
        press(8'h40);
        chk(o_data_lamps, 16'h1234);
        i_tgt_sel <= fpc_pkg::TGT_IR;
        press(8'h10);
        chk(o_data_lamps, 16'h7e01);
        i_tgt_sel <= 4'h3;
    endtask
    task automatic t_clk;
        int c0;
        i_clk_on <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        chk(o_cpu.clk_en, 1'b0);
        c0 = n_clk;
        press(8'h08);
        chk(n_clk - c0, 1);
        i_clk_on <= 1'b1;
    endtask
    task automatic t_run;
        int k;
        int d0;
        sw(16'h0005, 1'b0);
        i_mode_sel <= fpc_pkg::MODE_RUN;
        press(8'h01);
        chk(o_run_lamp, 1'b1);
        k = 0;
        while (i_cur_addr < 16'h0007 && k < 100) begin
            @(posedge i_clk_sys);
            k++;
        end
        repeat (2) @(posedge i_clk_sys);
        chk(o_data_lamps, i_cur_addr);
        chk({o_breakpoint_lamp, o_run_lamp}, 2'b11);
        press(8'h20);
        chk(u_fpc_cpu_model.regs[3], 16'h1234);
        i_breakpoint_sw <= 2'b01;
        repeat (3) @(posedge i_clk_sys);
        i_breakpoint_sw <= 2'b00;
        repeat (3) @(posedge i_clk_sys);
        chk(o_breakpoint_lamp, 1'b0);
        idle_cmd <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        idle_cmd <= 1'b0;
        chk({o_idle_lamp, o_run_lamp}, 2'b10);
        i_mode_sel <= fpc_pkg::MODE_SINGLE;
        d0 = n_done;
        press(8'h01);
        repeat (20) @(posedge i_clk_sys);
        chk(n_done - d0, 1);
        chk(o_idle_lamp, 1'b0);
        // breakpoint a few words ahead, armed; must stop there
        sw(i_cur_addr + 16'h0003, 1'b0);
        i_breakpoint_sw <= 2'b10;
        i_mode_sel <= fpc_pkg::MODE_RUN;
        press(8'h01);
        repeat (30) @(posedge i_clk_sys);
        wb(1'b0, fpc_pkg::OFS_STATUS, 32'h0);
        chk(rdat[2:0], fpc_pkg::ST_HALT);
        chk(o_breakpoint_lamp, 1'b1);
        sw(16'h0000, 1'b1);
        press(8'h01);
        wb(1'b0, fpc_pkg::OFS_STATUS, 32'h0);
        chk(rdat[2:0], fpc_pkg::ST_HALT);
        chk(o_run_lamp, 1'b0);
        i_breakpoint_sw <= 2'b00;
        sw(16'h0000, 1'b0);
    endtask
    task automatic t_boot;
        for (int m = 0; m < 2; m++) begin
            i_mode_sel <= m ? fpc_pkg::MODE_RUN : fpc_pkg::MODE_HALT;
            press(8'h04);
            repeat (300) @(posedge i_clk_sys);
            wb(1'b0, fpc_pkg::OFS_STATUS, 32'h0);
            chk(rdat[2:0], m ? fpc_pkg::ST_RUN : fpc_pkg::ST_HALT);
        end
        chk(u_fpc_cpu_model.mem[0], 16'hb000);
        chk(u_fpc_cpu_model.mem[255], 16'hb0ff);
        i_mode_sel <= fpc_pkg::MODE_HALT;
        repeat (10) @(posedge i_clk_sys);
    endtask
    task automatic t_reset;
        i_mem_pwr_lost <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_mem_pwr_lost <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        chk(o_pwr_fail_lamp, 1'b1);
        press(8'h02);
        chk(o_pwr_fail_lamp, 1'b0);
        chk({u_fpc_cpu_model.regs[0], u_fpc_cpu_model.regs[8]}, 32'h0);
        chk({u_fpc_cpu_model.regs[9], o_data_lamps}, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        t_enter;
        t_clk;
        t_run;
        t_boot;
        t_reset;
        give_verdict;
    end
    // whole run is some 1000 cycles; a hang ends it well past that
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_errors++;
        give_verdict;
    end
endmodule // tb
